//--- rtl/kes_pkg.sv
/*
 * kes_pkg: constants for the key function and event scheduler block.
 * assumes a 10 MHz system clock and an AXI4-Lite register bus.
 */
package kes_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ = 10_000;
	localparam int HOLD_TIME_MS = 1000;
	localparam int DISP_TIME_MS = 1000;
	localparam int HOLD_CYCLES = HOLD_TIME_MS * CLK_KHZ;
	localparam int DISP_CYCLES = DISP_TIME_MS * CLK_KHZ;
	localparam int CNT_W = 24;

	// ----------------------------------------------------------------
	// register map (byte offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CAL = 8'h08;
	localparam logic [7:0] OFS_SLOT0 = 8'h40;
	localparam int NUM_SLOTS = 14;
	localparam logic [31:0] CTRL_MASK = 32'h0000_1377;
	localparam logic [31:0] SLOT_MASK = 32'h070F_3F1F;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] SLOT_RESET = 32'h0000_0000;

	// ctrl fields
	localparam int CTRL_KEY0_LSB = 0;
	localparam int CTRL_KEY1_LSB = 4;
	localparam int CTRL_AUXSEL_LSB = 8;
	localparam int CTRL_DEFCLK_BIT = 12;
	localparam logic [1:0] AUX_SEL_KEY = 2'h2;

	// slot fields
	localparam int SLOT_HOUR_LSB = 0;
	localparam int SLOT_MIN_LSB = 8;
	localparam int SLOT_DAY_LSB = 16;
	localparam int SLOT_ACT_LSB = 24;

	// status fields
	localparam int ST_RUN_BIT = 0;
	localparam int ST_ECO_BIT = 1;
	localparam int ST_AUX_BIT = 2;
	localparam int ST_TURBO_BIT = 3;
	localparam int ST_REC_BIT = 4;
	localparam int ST_MSG_LSB = 8;
	localparam int ST_SCAN_BIT = 12;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// key function codes
	typedef enum logic [2:0] {
		KEY_OFF = 3'b000,
		KEY_AUX = 3'b001,
		KEY_ECO = 3'b010,
		KEY_STBY = 3'b011,
		KEY_TURBO = 3'b100,
		KEY_FORCE = 3'b101,
		KEY_HCLR = 3'b110,
		KEY_HREC = 3'b111
	} kes_key_e;

	// scheduled actions
	typedef enum logic [2:0] {
		ACT_OFF = 3'b000,
		ACT_ON = 3'b001,
		ACT_STBY = 3'b010,
		ACT_AUX_ON = 3'b011,
		ACT_AUX_OFF = 3'b100,
		ACT_DEFROST = 3'b101,
		ACT_ECO = 3'b110,
		ACT_NORMAL = 3'b111
	} kes_act_e;

	// display messages
	typedef enum logic [2:0] {
		MSG_NONE = 3'b000,
		MSG_NORMAL = 3'b001,
		MSG_ECO = 3'b010,
		MSG_DASH = 3'b011,
		MSG_REC_ON = 3'b100,
		MSG_REC_OFF = 3'b101
	} kes_msg_e;

	// day codes
	localparam logic [3:0] DAY_OFF = 4'h0;
	localparam logic [3:0] DAY_SAT = 4'h6;
	localparam logic [3:0] DAY_SUN = 4'h7;
	localparam logic [3:0] DAY_ALL = 4'h8;
	localparam logic [3:0] DAY_MON_FRI = 4'h9;
	localparam logic [3:0] DAY_MON_SAT = 4'hA;
	localparam logic [3:0] DAY_WEEKEND = 4'hB;

endpackage : kes_pkg

//--- rtl/kes_top.sv
/*
 * kes_top: two configurable front-panel keys and a 14-slot weekly
 * event scheduler, with an AXI4-Lite register slave.
 * assumes key pins and calendar clock fields come from outside the
 * aclk domain; calendar weekday is 1 (monday) to 7 (sunday).
 */
// Implementation choices: the register offsets and the AXI4-Lite register port.
// Function
// - key code off adds no extra action
// - code 1 toggles aux if aux select 2
// - key aux force holds until next event
// - code 2 swaps eco/normal, shows setpoint 1s
// - code 3 toggles on/standby, beats events (code: only a same-cycle tie; a later event overrides it)
// - turbo key starts or stops turbo cycle
// - forced switch toggles on/standby till event
// - code 6 clears alarms, shows dashes 1s
// - code 7 toggles recording, shows label 1s
// - fourteen independent disableable event slots
// - slot holds hour, minute, day, action
// - day codes 1..7 are monday..sunday
// - day 8 all, 9 mon-fri, 10 mon-sat, 11 weekend
// - day code off never fires
// - action codes 1..7 map to commands
// - scheduled defrost needs clock defrost mode
// - manual change lasts until next event
`timescale 1ns/1ns
module kes_top #(
	parameter int HOLD_CYCLES = kes_pkg::HOLD_CYCLES,
	parameter int DISP_CYCLES = kes_pkg::DISP_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// front-panel keys, high while pressed
	input wire logic [1:0] key_pressed,
	// calendar clock
	input wire logic [4:0] cal_hour,
	input wire logic [5:0] cal_minute,
	input wire logic [2:0] cal_weekday,
	// controlled functions
	output logic run_on,
	output logic eco_mode,
	output logic aux_out,
	output logic turbo_active,
	output logic defrost_start,
	output logic alarm_clear,
	output logic alarm_rec_en,
	output kes_pkg::kes_msg_e disp_msg
);
	import kes_pkg::*;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic day_hit(input logic [3:0] day, input logic [2:0] wd);
		case (day)
			DAY_ALL: day_hit = 1'b1;
			DAY_MON_FRI: day_hit = (wd >= 3'd1) && (wd <= 3'd5);
			DAY_MON_SAT: day_hit = (wd >= 3'd1) && (wd <= 3'd6);
			DAY_WEEKEND: day_hit = (wd == DAY_SAT[2:0]) || (wd == DAY_SUN[2:0]);
			DAY_OFF: day_hit = 1'b0;
			default: day_hit = (day <= DAY_SUN) && (day[2:0] == wd);
		endcase
	endfunction : day_hit

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			res[8*b +: 8] = strb[b] ? nw[8*b +: 8] : res[8*b +: 8];
		end
		return res & mask;
	endfunction : merge

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] key_m_q, key_s_q;
	logic [13:0] cal_m_q, cal_s_q, cal_p_q;
	wire [13:0] cal_raw = {cal_hour, cal_minute, cal_weekday};
	// multi-bit time may tear on a change; act only once two samples agree
	wire cal_stable = (cal_s_q == cal_p_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_m_q <= '0;
			key_s_q <= '0;
			cal_m_q <= '0;
			cal_s_q <= '0;
			cal_p_q <= '0;
		end else begin
			key_m_q <= key_pressed;
			key_s_q <= key_m_q;
			cal_m_q <= cal_raw;
			cal_s_q <= cal_m_q;
			cal_p_q <= cal_s_q;
		end
	end

	// ----------------------------------------------------------------
	// register file and axi slave
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q, rdata_q, status_w;
	logic [31:0] slot_q [NUM_SLOTS];
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;

	wire wr_go = awvalid && wvalid && !awready_q && !bvalid_q;
	wire ar_go = arvalid && !arready_q && !rvalid_q;
	wire [5:0] wr_idx = awaddr[7:2];
	wire [5:0] rd_idx = araddr[7:2];
	wire [5:0] slot_base = OFS_SLOT0[7:2];
	wire wr_slot = (wr_idx >= slot_base) && (wr_idx < slot_base + 6'(NUM_SLOTS));
	wire rd_slot = (rd_idx >= slot_base) && (rd_idx < slot_base + 6'(NUM_SLOTS));
	wire [3:0] wr_sn = 4'(wr_idx - slot_base);
	wire [3:0] rd_sn = 4'(rd_idx - slot_base);
	wire wr_ctrl = (awaddr[7:2] == OFS_CTRL[7:2]);
	wire wr_ro = (awaddr[7:2] == OFS_STATUS[7:2]) || (awaddr[7:2] == OFS_CAL[7:2]);
	wire wr_ok = wr_ctrl || wr_ro || wr_slot;
	wire rd_ctrl = (rd_idx == OFS_CTRL[7:2]);
	wire rd_stat = (rd_idx == OFS_STATUS[7:2]);
	wire rd_cal = (rd_idx == OFS_CAL[7:2]);
	wire rd_ok = rd_ctrl || rd_stat || rd_cal || rd_slot;
	wire [31:0] rd_word = rd_ctrl ? ctrl_q : rd_stat ? status_w :
		rd_cal ? {18'h0, cal_p_q} : rd_slot ? slot_q[rd_sn] : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
			ctrl_q <= CTRL_RESET;
			for (int i = 0; i < NUM_SLOTS; i++) begin
				slot_q[i] <= SLOT_RESET;
			end
		end else begin
			awready_q <= wr_go;
			wready_q <= wr_go;
			arready_q <= ar_go;
			if (awready_q) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
				if (wr_ctrl) begin
					ctrl_q <= merge(ctrl_q, wdata, wstrb, CTRL_MASK);
				end
				if (wr_slot) begin
					slot_q[wr_sn] <= merge(slot_q[wr_sn], wdata, wstrb, SLOT_MASK);
				end
			end else if (bready) begin
				bvalid_q <= 1'b0;
			end
			if (arready_q) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// long-press detection
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] hold_cnt_q [2];
	logic [1:0] held_q;
	logic [1:0] long_press;

	// fires once per press, at the threshold, never on a short press
	assign long_press[0] = key_s_q[0] && !held_q[0] && (hold_cnt_q[0] == CNT_W'(HOLD_CYCLES - 1));
	assign long_press[1] = key_s_q[1] && !held_q[1] && (hold_cnt_q[1] == CNT_W'(HOLD_CYCLES - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_q <= '0;
			hold_cnt_q[0] <= '0;
			hold_cnt_q[1] <= '0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (!key_s_q[k]) begin
					hold_cnt_q[k] <= '0;
					held_q[k] <= 1'b0;
				end else if (long_press[k]) begin
					held_q[k] <= 1'b1;
				end else if (!held_q[k]) begin
					hold_cnt_q[k] <= hold_cnt_q[k] + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// event scan: one slot per cycle after each new minute
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		SC_IDLE = 1'b0,
		SC_SCAN = 1'b1
	} kes_scan_e;
	kes_scan_e scan_q;
	logic [3:0] scan_idx_q;
	logic [13:0] last_q;

	// a fresh real time stamp starts one pass; weekday 0 is only the sync reset
	wire new_time = cal_stable && (cal_p_q != last_q) && (cal_p_q[2:0] != 3'h0) &&
		(scan_q == SC_IDLE);
	wire [31:0] cur_slot = slot_q[scan_idx_q];
	wire slot_hit = (scan_q == SC_SCAN) &&
		(cur_slot[SLOT_HOUR_LSB +: 5] == last_q[13:9]) &&
		(cur_slot[SLOT_MIN_LSB +: 6] == last_q[8:3]) &&
		day_hit(cur_slot[SLOT_DAY_LSB +: 4], last_q[2:0]);
	wire [2:0] hit_act = slot_hit ? cur_slot[SLOT_ACT_LSB +: 3] : ACT_OFF;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scan_q <= SC_IDLE;
			scan_idx_q <= '0;
			last_q <= '1;
		end else begin
			case (scan_q)
				SC_IDLE: begin
					if (new_time) begin
						last_q <= cal_p_q;
						scan_idx_q <= '0;
						scan_q <= SC_SCAN;
					end
				end
				SC_SCAN: begin
					if (scan_idx_q == 4'(NUM_SLOTS - 1)) begin
						scan_q <= SC_IDLE;
					end
					scan_idx_q <= scan_idx_q + 1'b1;
				end
				default: scan_q <= SC_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// function state: event first, then keys, so keys win a tie
	// ----------------------------------------------------------------
	logic run_q, eco_q, aux_q, turbo_q, def_q, clr_q, rec_q;
	logic run_d, eco_d, aux_d, turbo_d, def_d, clr_d, rec_d;
	kes_msg_e msg_q, msg_d;
	logic [CNT_W-1:0] disp_cnt_q;
	logic msg_load;
	wire [2:0] key_code [2];
	assign key_code[0] = ctrl_q[CTRL_KEY0_LSB +: 3];
	assign key_code[1] = ctrl_q[CTRL_KEY1_LSB +: 3];
	wire aux_by_key = (ctrl_q[CTRL_AUXSEL_LSB +: 2] == AUX_SEL_KEY);
	wire def_by_clock = ctrl_q[CTRL_DEFCLK_BIT];

	always_comb begin
		run_d = run_q;
		eco_d = eco_q;
		aux_d = aux_q;
		turbo_d = turbo_q;
		rec_d = rec_q;
		def_d = 1'b0;
		clr_d = 1'b0;
		msg_d = msg_q;
		msg_load = 1'b0;
		// a later event simply overwrites any manual setting
		case (hit_act)
			ACT_ON: run_d = 1'b1;
			ACT_STBY: run_d = 1'b0;
			ACT_AUX_ON: aux_d = 1'b1;
			ACT_AUX_OFF: aux_d = 1'b0;
			ACT_DEFROST: def_d = def_by_clock;
			ACT_ECO: eco_d = 1'b1;
			ACT_NORMAL: eco_d = 1'b0;
			default: run_d = run_d;
		endcase
		for (int k = 0; k < 2; k++) begin
			if (long_press[k]) begin
				case (key_code[k])
					KEY_AUX: aux_d = aux_by_key ? !aux_d : aux_d;
					KEY_ECO: begin
						eco_d = !eco_d;
						msg_d = eco_d ? MSG_ECO : MSG_NORMAL;
						msg_load = 1'b1;
					end
					KEY_STBY: run_d = !run_d;
					KEY_TURBO: turbo_d = !turbo_d;
					KEY_FORCE: run_d = !run_d;
					KEY_HCLR: begin
						clr_d = 1'b1;
						msg_d = MSG_DASH;
						msg_load = 1'b1;
					end
					KEY_HREC: begin
						rec_d = !rec_d;
						msg_d = rec_d ? MSG_REC_ON : MSG_REC_OFF;
						msg_load = 1'b1;
					end
					default: msg_load = msg_load;
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{run_q, eco_q, aux_q, turbo_q, rec_q, def_q, clr_q} <= 7'h44;
		end else begin
			{run_q, eco_q, aux_q, turbo_q, rec_q, def_q, clr_q} <=
				{run_d, eco_d, aux_d, turbo_d, rec_d, def_d, clr_d};
		end
	end

	// message shown for the display time, then cleared
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			msg_q <= MSG_NONE;
			disp_cnt_q <= '0;
		end else if (msg_load) begin
			msg_q <= msg_d;
			disp_cnt_q <= CNT_W'(DISP_CYCLES - 1);
		end else if (disp_cnt_q != '0) begin
			disp_cnt_q <= disp_cnt_q - 1'b1;
		end else begin
			msg_q <= MSG_NONE;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign status_w = {19'h0, (scan_q == SC_SCAN), 1'b0, msg_q, 3'h0,
		rec_q, turbo_q, aux_q, eco_q, run_q};
	assign {awready, wready, bvalid, arready, rvalid} =
		{awready_q, wready_q, bvalid_q, arready_q, rvalid_q};
	assign {bresp, rresp, rdata} = {bresp_q, rresp_q, rdata_q};
	assign {run_on, eco_mode, aux_out, turbo_active} = {run_q, eco_q, aux_q, turbo_q};
	assign {defrost_start, alarm_clear, alarm_rec_en} = {def_q, clr_q, rec_q};
	assign disp_msg = msg_q;

endmodule : kes_top

//--- tb/kes_panel.sv
/*
 * kes_panel: model of the front-panel keys and the calendar clock.
 * assumes the bench calls its tasks from the aclk domain.
 */
`timescale 1ns/1ns
module kes_panel (
	// clock
	input wire logic aclk,
	// towards the block
	output logic [1:0] key_pressed,
	output logic [4:0] cal_hour,
	output logic [5:0] cal_minute,
	output logic [2:0] cal_weekday
);
	initial begin
		key_pressed = 2'b00;
		cal_hour = 5'h00;
		cal_minute = 6'h00;
		cal_weekday = 3'h1;
	end

	// hold one key for n cycles, then let go
	task automatic press(input int k, input int n);
		@(posedge aclk);
		key_pressed[k] <= 1'b1;
		repeat (n) @(posedge aclk);
		key_pressed[k] <= 1'b0;
	endtask : press

	// all fields move on one edge; the block's syncs must absorb it
	task automatic set_time(input logic [4:0] h, input logic [5:0] m, input logic [2:0] d);
		@(posedge aclk);
		cal_hour <= h;
		cal_minute <= m;
		cal_weekday <= d;
	endtask : set_time
endmodule : kes_panel

//--- tb/kes_top_props.sv
/*
 * kes_top_props: assertions on the kes_top ports.
 * assumes one clock domain; bound to every kes_top instance.
 */
`timescale 1ns/1ns
module kes_top_props #(
	parameter int HOLD_CYCLES = 20,
	parameter int DISP_CYCLES = 30
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// panel side
	input wire logic [1:0] key_pressed,
	input wire logic [4:0] cal_hour,
	input wire logic [5:0] cal_minute,
	input wire logic [2:0] cal_weekday,
	// functions
	input wire logic run_on,
	input wire logic eco_mode,
	input wire logic aux_out,
	input wire logic turbo_active,
	input wire logic defrost_start,
	input wire logic alarm_clear,
	input wire logic alarm_rec_en,
	input wire kes_pkg::kes_msg_e disp_msg
);
	import kes_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----------------
	// helper counters
	// ----------------
	// hold_q and age_q saturate, so a long hold cannot wrap into a false fail
	wire [13:0] cal_now = {cal_hour, cal_minute, cal_weekday};
	logic [15:0] hold_q;
	logic [15:0] age_q;
	logic [15:0] msg_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_q <= '0;
			age_q <= '0;
			msg_q <= '0;
		end else begin
			hold_q <= (key_pressed == 2'b00) ? '0 : hold_q + 16'(hold_q != 16'hffff);
			age_q <= $changed(cal_now) ? '0 : age_q + 16'(age_q != 16'hffff);
			msg_q <= (disp_msg == MSG_NONE || $changed(disp_msg)) ? '0 : msg_q + 16'h0001;
		end
	end
	// ----------------
	// properties
	// ----------------
	sequence s_msg_up;
		$changed(disp_msg) && disp_msg != MSG_NONE;
	endsequence
	sequence s_msg_kept;
		(disp_msg != MSG_NONE) [*8];
	endsequence
	a_msg_stays: assert property (s_msg_up |=> s_msg_kept)
		else $error("display message dropped early");
	a_msg_bound: assert property (msg_q <= DISP_CYCLES + 2)
		else $error("display message held too long");
	a_clear_dash: assert property (alarm_clear |-> disp_msg == MSG_DASH)
		else $error("alarm clear without dash message");
	a_clear_pulse: assert property (alarm_clear |=> !alarm_clear)
		else $error("alarm clear longer than one cycle");
	a_dfr_pulse: assert property (defrost_start |=> !defrost_start)
		else $error("defrost start repeated");
	a_rec_long: assert property ($changed(alarm_rec_en) |-> $past(hold_q, 3) >= HOLD_CYCLES - 4)
		else $error("recording toggled without long press");
	a_turbo_long: assert property ($changed(turbo_active) |-> $past(hold_q, 3) >= HOLD_CYCLES - 4)
		else $error("turbo toggled without long press");
	a_mode_cause: assert property ($changed({run_on, eco_mode, aux_out})
		|-> $past(hold_q, 3) >= HOLD_CYCLES - 4 || age_q < 32)
		else $error("mode changed with no key or time step");
endmodule : kes_top_props

bind kes_top kes_top_props #(.HOLD_CYCLES(HOLD_CYCLES), .DISP_CYCLES(DISP_CYCLES)) u_props (
	.aclk, .aresetn, .key_pressed, .cal_hour, .cal_minute, .cal_weekday, .run_on, .eco_mode,
	.aux_out, .turbo_active, .defrost_start, .alarm_clear, .alarm_rec_en, .disp_msg);

//--- tb/testbench.sv
/*
 * testbench: self-checking bench for kes_top with the panel model.
 * assumes short hold and display counts, set below.
 */
`timescale 1ns/1ns
module testbench import kes_pkg::*;;
	localparam int HOLD = 20;
	localparam int DISP = 30;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic run_on, eco_mode, aux_out, turbo_active, defrost_start, alarm_clear, alarm_rec_en;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, key_pressed;
	logic [4:0] cal_hour, st;
	logic [5:0] cal_minute;
	logic [2:0] cal_weekday;
	kes_msg_e disp_msg;
	int miscompares, checked, cycles, n_dfr, n_clr;
	wire [4:0] st_seen = {alarm_rec_en, turbo_active, aux_out, eco_mode, run_on};

	kes_top #(.HOLD_CYCLES(HOLD), .DISP_CYCLES(DISP)) dut (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .key_pressed, .cal_hour, .cal_minute,
		.cal_weekday, .run_on, .eco_mode, .aux_out, .turbo_active, .defrost_start, .alarm_clear,
		.alarm_rec_en, .disp_msg);
	kes_panel panel (.aclk, .key_pressed, .cal_hour, .cal_minute, .cal_weekday);

	// ----------------
	// clock, timeout, pulse counters
	// ----------------
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		n_dfr <= n_dfr + int'(defrost_start);
		n_clr <= n_clr + int'(alarm_clear);
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ----------------
	// shared tasks
	// ----------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit ka;
		bit kw;
		ka = 0;
		kw = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			ka |= awready;
			kw |= wready;
			awvalid <= !ka;
			wvalid <= !kw;
		end while (!(ka && kw));
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rdx(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rdx
	function automatic logic [7:0] slot(input int i);
		return OFS_SLOT0 + 8'(4 * i);
	endfunction : slot
	function automatic logic [31:0] slot_val(logic [4:0] h, logic [5:0] m, logic [3:0] d,
		logic [2:0] a);
		return {5'h00, a, 4'h0, d, 2'h0, m, 3'h0, h};
	endfunction : slot_val

	// ----------------
	// expectations
	// ----------------
	function automatic logic [4:0] key_st(logic [2:0] c, logic [4:0] s, bit ax);
		case (c)
			3'd1: return ax ? s ^ 5'h04 : s;
			3'd2: return s ^ 5'h02;
			3'd3, 3'd5: return s ^ 5'h01;
			3'd4: return s ^ 5'h08;
			3'd7: return s ^ 5'h10;
			default: return s;
		endcase
	endfunction : key_st
	function automatic logic [2:0] key_msg(logic [2:0] c, logic [4:0] s);
		case (c)
			3'd2: return s[1] ? MSG_ECO : MSG_NORMAL;
			3'd6: return MSG_DASH;
			3'd7: return s[4] ? MSG_REC_ON : MSG_REC_OFF;
			default: return MSG_NONE;
		endcase
	endfunction : key_msg
	function automatic logic [4:0] act_st(logic [2:0] a, logic [4:0] s);
		case (a)
			ACT_ON: s[0] = 1'b1;
			ACT_STBY: s[0] = 1'b0;
			ACT_AUX_ON: s[2] = 1'b1;
			ACT_AUX_OFF: s[2] = 1'b0;
			ACT_ECO: s[1] = 1'b1;
			ACT_NORMAL: s[1] = 1'b0;
			default: s = s;
		endcase
		return s;
	endfunction : act_st
	function automatic bit day_hit(logic [3:0] d, logic [2:0] w);
		case (d)
			DAY_ALL: return 1'b1;
			DAY_MON_FRI: return w <= 3'd5;
			DAY_MON_SAT: return w <= 3'd6;
			DAY_WEEKEND: return w >= 3'd6;
			default: return d == 4'(w);
		endcase
	endfunction : day_hit

	// ----------------
	// scenarios
	// ----------------
	task automatic key_test(input logic [2:0] c, input bit ax, input int n);
		int k;
		int nc;
		logic [2:0] m;
		k = $urandom_range(1);
		nc = n_clr;
		wr(OFS_CTRL, (32'(c) << (4 * k)) | (ax ? 32'h0000_0200 : 32'h0000_0100), rs);
		panel.press(k, n);
		m = MSG_NONE;
		if (n > HOLD) begin
			st = key_st(c, st, ax);
			m = key_msg(c, st);
		end
		repeat (2) @(posedge aclk);
		check(32'(st_seen), 32'(st));
		check(32'(disp_msg), 32'(m));
		check(32'(n_clr - nc), 32'(c == 3'd6 && n > HOLD));
		repeat (DISP + 5) @(posedge aclk);
		check(32'(disp_msg), 32'(MSG_NONE));
	endtask : key_test
	task automatic tick(input logic [4:0] h, input logic [5:0] m, input logic [2:0] d);
		panel.set_time(h, m, d);
		repeat (30) @(posedge aclk);
	endtask : tick
	task automatic act_pass(input bit dc);
		int nd;
		wr(OFS_CTRL, dc ? 32'h0000_1000 : 32'h0000_0000, rs);
		for (int a = 1; a < 8; a++) begin
			wr(slot(0), slot_val(5'd3, 6'(a), DAY_ALL, 3'(a)), rs);
			nd = n_dfr;
			tick(5'd3, 6'(a), 3'd2);
			st = act_st(3'(a), st);
			check(32'(st_seen), 32'(st));
			check(32'(n_dfr - nd), 32'(a == 5 && dc));
		end
	endtask : act_pass

	initial begin
		logic [4:0] h;
		logic [31:0] v;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hf;
		st = 5'h11;
		void'($urandom(32'hd90b_a342));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (30) @(posedge aclk);
		rdx(OFS_STATUS, rd, rs);
		check(rd, 32'h0000_0011);
		wr(8'h78, 32'h0000_0101, rs);
		check(32'(rs), 32'(RESP_SLVERR));
		rdx(8'h78, rd, rs);
		check({rd[29:0], rs}, 32'(RESP_SLVERR));
		for (int c = 0; c < 8; c++) begin
			key_test(3'(c), 1'b1, HOLD + 5);
		end
		key_test(3'd1, 1'b0, HOLD + 5);
		key_test(3'd7, 1'b1, HOLD / 2);
		h = 5'($urandom_range(23));
		wr(slot(1), slot_val(h, 6'd10, DAY_ALL, ACT_AUX_OFF), rs);
		for (int d = 0; d < 16; d++) begin
			wr(slot(0), slot_val(h, 6'd11, 4'(d), ACT_AUX_ON), rs);
			for (int w = 1; w < 8; w++) begin
				tick(h, 6'd10, 3'(w));
				tick(h, 6'd11, 3'(w));
				check(32'(aux_out), 32'(day_hit(4'(d), 3'(w))));
			end
		end
		st[2] = 1'b0;
		act_pass(1'b0);
		act_pass(1'b1);
		key_test(3'd2, 1'b1, HOLD + 5);
		tick(5'd3, 6'd6, 3'd2);
		tick(5'd3, 6'd7, 3'd2);
		st = act_st(ACT_NORMAL, st);
		check(32'(st_seen), 32'(st));
		for (int i = 0; i < NUM_SLOTS; i++) begin
			v = $urandom;
			wr(slot(i), v, rs);
			rdx(slot(i), rd, rs);
			check(rd, v & SLOT_MASK);
		end
		wrap_up();
	end
endmodule : testbench
